// *** lcd_link_regs.svh ***
// Purpose: Constants shared by both ends of the write-only LCD serial link
// Assumes: 50 MHz system clock on both ends
// Notes:   Command codes are inclusive ranges of the command byte
`ifndef LCD_LINK_REGS_SVH
`define LCD_LINK_REGS_SVH

// ****************************************
// Timing
// ****************************************
`define CLK_RATE_KHZ        50000
`define SCLK_RATE_KHZ       3125
`define SCLK_HALF_CYC       (`CLK_RATE_KHZ / (2 * `SCLK_RATE_KHZ))
`define BITS_PER_BYTE       8

// ****************************************
// Command code ranges
// ****************************************
`define CMD_SCAN_LO         8'hc0
`define CMD_SCAN_HI         8'hcf
`define CMD_POWER_LO        8'h28
`define CMD_POWER_HI        8'h2f
`define CMD_START_LO        8'h40
`define CMD_START_HI        8'h7f
`define CMD_PAGE_LO         8'hb0
`define CMD_PAGE_HI         8'hb8
`define CMD_COL_LO          8'h00
`define CMD_COL_HI          8'h18
`define CMD_DISP_OFF        8'hae
`define CMD_DISP_ON         8'haf
`define NUM_PAGES           8

// ****************************************
// Command class positions and reset values
// ****************************************
`define CLS_SCAN            0
`define CLS_POWER           1
`define CLS_START           2
`define CLS_PAGE            3
`define CLS_COL             4
`define CLS_DISP            5
`define NUM_CLS             6
`define RST_SEEN            6'h00
`define RST_BYTE            8'h00

`endif

// *** lcd_link_pkg.sv ***
// Purpose: Types and command decode shared by both link ends
// Assumes: lcd_link_regs.svh holds every figure
// Notes:   Decode returns one bit per command class
`include "lcd_link_regs.svh"

package lcd_link_pkg;

    typedef logic [7:0]           byte_t;
    typedef logic [`NUM_CLS-1:0]  cls_t;

    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_SETUP = 3'b001,
        H_HIGH  = 3'b010,
        H_LOW   = 3'b011,
        H_GAP   = 3'b100
    } host_state_t;

    // One-hot class of a command byte, zero for codes outside every range
    function automatic cls_t cmd_class(input byte_t b);
        cls_t c;
        c = '0;
        c[`CLS_SCAN]  = (b >= `CMD_SCAN_LO)  && (b <= `CMD_SCAN_HI);
        c[`CLS_POWER] = (b >= `CMD_POWER_LO) && (b <= `CMD_POWER_HI);
        c[`CLS_START] = (b >= `CMD_START_LO) && (b <= `CMD_START_HI);
        c[`CLS_PAGE]  = (b >= `CMD_PAGE_LO)  && (b <= `CMD_PAGE_HI);
        c[`CLS_COL]   = (b <= `CMD_COL_HI);
        c[`CLS_DISP]  = (b == `CMD_DISP_OFF) || (b == `CMD_DISP_ON);
        return c;
    endfunction : cmd_class

endpackage : lcd_link_pkg

// *** lcd_link_if.sv ***
// Purpose: Pins between the host serial master and the LCD controller
// Assumes: All pins are one-way, driven by the host
// Notes:   No return data line exists on this link
`timescale 1ns/1ps

interface lcd_link_if;
    logic lcd_serial_clock;     // Serial clock, idles low
    logic lcd_chip_select_b;    // Chip select, active low
    logic lcd_serial_in;        // Host-to-LCD data, MSB first
    logic data_command_select;  // High data, low command
    logic lcd_reset_b;          // LCD reset, active low
    logic backlight_enable;     // High turns the backlight on

    modport host (
        output lcd_serial_clock,
        output lcd_chip_select_b,
        output lcd_serial_in,
        output data_command_select,
        output lcd_reset_b,
        output backlight_enable
    );

    modport lcd (
        input  lcd_serial_clock,
        input  lcd_chip_select_b,
        input  lcd_serial_in,
        input  data_command_select,
        input  lcd_reset_b,
        input  backlight_enable
    );
endinterface : lcd_link_if

// *** lcd_lcd_end.sv ***
// Purpose: LCD controller end: receives command and data bytes
// Assumes: Host keeps select stable through each chip-select frame
// Notes:   Every link pin passes a two-stage synchroniser first
`timescale 1ns/1ps
`include "lcd_link_regs.svh"

module lcd_lcd_end (
    input  wire logic                 clk,          // System clock
    input  wire logic                 rst_b,        // Synchronous reset, active low
    input  wire logic                 clk_en,       // Freezes all state while low
    lcd_link_if.lcd                   link,         // Link pins from host
    output logic                      lcd_in_reset, // LCD held in reset
    output logic                      backlight_on, // Backlight lit
    output logic                      display_on,   // Display enabled
    output logic [5:0]                start_line,   // Display start line
    output logic [3:0]                page,         // Current page
    output logic [7:0]                column,       // Current column
    output logic [3:0]                scan_mode,    // Common output scan mode
    output logic [2:0]                power_mode,   // Power control setting
    output logic                      init_done,    // All init classes seen
    output logic                      pix_valid,    // Pulse: display byte written
    output logic [3:0]                pix_page,     // Page of written byte
    output logic [7:0]                pix_column,   // Column of written byte
    output lcd_link_pkg::byte_t       pix_byte,     // Written display byte
    output logic                      cmd_valid,    // Pulse: command received
    output lcd_link_pkg::byte_t       cmd_byte,     // Received command
    output logic                      early_data    // Pulse: data before init
);
    import lcd_link_pkg::*;

    // ****************************************
    // Synchronisers
    // ****************************************
    localparam int NP = 6;
    logic [NP-1:0] pin_raw;
    logic [NP-1:0] sync1;
    logic [NP-1:0] sync2;
    assign pin_raw = {link.backlight_enable, link.lcd_reset_b, link.data_command_select,
                      link.lcd_serial_in, link.lcd_chip_select_b, link.lcd_serial_clock};

    // One generate loop per pin; sync1 is read only by sync2
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else if (clk_en) begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    wire s_sclk = sync2[0];
    wire s_cs_b = sync2[1];
    wire s_mosi = sync2[2];
    wire s_dc   = sync2[3];
    wire s_rstb = sync2[4];
    wire s_bk   = sync2[5];

    // ****************************************
    // Shift receiver
    // ****************************************
    logic  sclk_prev;
    logic  [2:0] bit_cnt;
    byte_t shift;
    wire   sclk_rise = s_sclk && !sclk_prev;
    wire   lcd_rst   = !s_rstb;                                   // R4
    wire   take_bit  = sclk_rise && !s_cs_b && !lcd_rst;          // R1
    wire   last_bit  = take_bit && (bit_cnt == 3'(`BITS_PER_BYTE - 1));
    byte_t next_shift;
    assign next_shift = {shift[6:0], s_mosi};                     // R16

    // Bits count only inside a frame; deselect restarts the byte
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sclk_prev <= 1'b0;
            bit_cnt   <= 3'h0;
            shift     <= `RST_BYTE;
        end else if (clk_en) begin
            sclk_prev <= s_sclk;
            if (s_cs_b || lcd_rst) begin
                bit_cnt <= 3'h0;
            end else if (take_bit) begin
                bit_cnt <= bit_cnt + 3'h1;
                shift   <= next_shift;
            end
        end
    end

    // ****************************************
    // Command and data decode
    // ****************************************
    wire   got_data = last_bit && s_dc;                           // R2
    wire   got_cmd  = last_bit && !s_dc;                          // R3
    cls_t  cls;
    cls_t  seen;
    cls_t  next_seen;
    assign cls       = cmd_class(next_shift);
    assign next_seen = seen | (got_cmd ? cls : '0);
    assign init_done = &seen;                                     // R6
    assign lcd_in_reset = lcd_rst;                                // R4

    // Config state; LCD reset wipes it back to defaults
    always_ff @(posedge clk) begin
        if (!rst_b || (clk_en && lcd_rst)) begin
            seen <= `RST_SEEN;
            display_on <= 1'b0;
            start_line <= 6'h00;
            page       <= 4'h0;
            column     <= 8'h00;
            scan_mode  <= 4'h0;
            power_mode <= 3'h0;
        end else if (clk_en) begin
            seen <= next_seen;
            if (got_cmd && cls[`CLS_SCAN])  scan_mode  <= next_shift[3:0];      // R7
            if (got_cmd && cls[`CLS_POWER]) power_mode <= next_shift[2:0];      // R8
            if (got_cmd && cls[`CLS_START]) start_line <= next_shift[5:0];      // R9
            if (got_cmd && cls[`CLS_PAGE])  page       <= next_shift[3:0];      // R10
            if (got_cmd && cls[`CLS_COL])   column     <= {3'h0, next_shift[4:0]}; // R11
            if (got_cmd && cls[`CLS_DISP])  display_on <= next_shift[0];        // R12
            // Column advances after each stored byte, as a write stream expects
            if (got_data && init_done) column <= column + 8'h01;
        end
    end

    // Output strobes and registered data
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pix_valid  <= 1'b0;
            cmd_valid  <= 1'b0;
            early_data <= 1'b0;
            pix_page   <= 4'h0;
            pix_column <= 8'h00;
            pix_byte   <= `RST_BYTE;
            cmd_byte   <= `RST_BYTE;
            backlight_on <= 1'b0;
        end else if (clk_en) begin
            pix_valid  <= got_data && init_done;
            early_data <= got_data && !init_done;                 // R6
            cmd_valid  <= got_cmd;
            backlight_on <= s_bk;                                 // R5
            if (got_data) begin
                pix_page   <= page;
                pix_column <= column;
                pix_byte   <= next_shift;
            end
            if (got_cmd) cmd_byte <= next_shift;
        end
    end
endmodule : lcd_lcd_end

// *** lcd_host_end.sv ***
// Overview of operation
// R1: Transmit only: clock, select, data out
// R2: Select high marks a display data byte
// R3: Select low marks a command byte
// R4: LCD reset line is active low
// R5: Backlight line high lights, low darkens
// R6: Finish init commands before any data
// R7: Codes c0 to cf set scan mode
// R8: Codes 28 to 2f set power control
// R9: Codes 40 to 7f set start line
// R10: Codes b0 to b8 set page
// R11: Codes 00 to 18 set column
// R12: Code ae display off, af on
// R13: Eight pages; set page, column before data
// R14: Transmit only, serial clock at 3.125 MHz
// R15: Select stable through each byte frame
// R16: MSB first, select low during byte
//
// Purpose: Host serial master end: sends one byte per chip-select frame
// Assumes: User side offers bytes with a valid/ready handshake
// Notes:   Serial clock is made here by a divider from clk
`timescale 1ns/1ps
`include "lcd_link_regs.svh"

module lcd_host_end (
    input  wire logic                 clk,            // System clock
    input  wire logic                 rst_b,          // Synchronous reset, active low
    input  wire logic                 clk_en,         // Freezes all state while low
    input  wire logic                 req_valid,      // Byte offered
    output logic                      req_ready,      // Byte taken this cycle
    input  wire logic                 req_is_data,    // High data, low command
    input  wire lcd_link_pkg::byte_t  req_byte,       // Byte to send
    output logic                      req_refused,    // Pulse: data dropped
    input  wire logic                 backlight_req,  // Light the backlight
    input  wire logic                 lcd_reset_req,  // Hold the LCD in reset
    output logic                      init_done,      // Init sequence complete
    output logic                      busy,           // Frame in progress
    lcd_link_if.host                  link            // Link pins to LCD
);
    import lcd_link_pkg::*;

    // ****************************************
    // Divider and state
    // ****************************************
    localparam int HALF = `SCLK_HALF_CYC;                         // R14
    localparam logic [3:0] HALF_LAST = 4'(HALF - 1);

    host_state_t state;
    host_state_t next_state;
    logic  [3:0] div_cnt;
    logic  [2:0] bit_idx;

    byte_t shift;
    logic  dc_hold;
    cls_t  seen;

    // Phase decode and user handshake
    wire   half_done = (div_cnt == HALF_LAST);
    wire   last_bit  = (bit_idx == 3'(`BITS_PER_BYTE - 1));
    wire   accept    = req_valid && req_ready;
    wire   allowed   = !req_is_data || init_done;                 // R6 R13
    wire   start     = accept && allowed;

    cls_t  req_cls;
    assign req_cls   = cmd_class(req_byte);

    assign init_done = &seen;                                     // R6 R13
    assign req_ready = (state == H_IDLE) && clk_en && !lcd_reset_req;
    assign busy      = (state != H_IDLE);

    // Next state: each phase but idle lasts half a serial clock period
    always_comb begin
        next_state = state;

        case (state)
            H_IDLE: begin
                if (start) next_state = H_SETUP;
            end

            H_SETUP: begin
                if (half_done) next_state = H_HIGH;
            end

            H_HIGH: begin
                if (half_done) next_state = last_bit ? H_GAP : H_LOW;
            end

            H_LOW: begin
                if (half_done) next_state = H_HIGH;
            end

            H_GAP: begin
                if (half_done) next_state = H_IDLE;
            end

            default: begin
                next_state = H_IDLE;
            end
        endcase
    end

    // State, divider and bit counter
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state   <= H_IDLE;
            div_cnt <= 4'h0;
            bit_idx <= 3'h0;
        end else if (clk_en) begin
            state <= next_state;

            if (state == H_IDLE || half_done) begin
                div_cnt <= 4'h0;
            end else begin
                div_cnt <= div_cnt + 4'h1;
            end

            if (state == H_IDLE) begin
                bit_idx <= 3'h0;
            end else if (state == H_HIGH && half_done) begin
                bit_idx <= bit_idx + 3'h1;
            end
        end
    end

    // ****************************************
    // Byte capture and shifting
    // ****************************************
    // Select is latched at acceptance so it cannot move mid-frame
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shift   <= `RST_BYTE;
            dc_hold <= 1'b0;
        end else if (clk_en) begin
            if (start) begin
                shift   <= req_byte;
                dc_hold <= req_is_data;                           // R15
            end else if (state == H_HIGH && half_done) begin
                shift   <= {shift[6:0], 1'b0};                    // R16
            end
        end
    end

    // ****************************************
    // Init tracking
    // ****************************************
    // One flag per command class; an LCD reset forces a fresh init
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_CLS; gi++) begin : g_seen
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    seen[gi] <= 1'b0;
                end else if (clk_en) begin
                    if (start && !req_is_data && req_cls[gi]) begin
                        seen[gi] <= 1'b1;                         // R7 R8 R9 R10 R11 R12
                    end else if (lcd_reset_req) begin
                        seen[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Refusal is reported one cycle after the drop
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            req_refused <= 1'b0;
        end else if (clk_en) begin
            req_refused <= accept && !allowed;                    // R6
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    // Registered pins avoid glitches on the LCD's serial clock
    wire   frame    = (state == H_SETUP) || (state == H_HIGH) || (state == H_LOW);
    wire   next_clk = (next_state == H_HIGH);
    wire   next_cs  = (next_state == H_SETUP) || (next_state == H_HIGH)
                   || (next_state == H_LOW);

    byte_t next_bits;
    assign next_bits = (state == H_IDLE) ? req_byte
                     : (state == H_HIGH && half_done) ? {shift[6:0], 1'b0} : shift;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            link.lcd_serial_clock    <= 1'b0;
            link.lcd_chip_select_b   <= 1'b1;
            link.lcd_serial_in       <= 1'b0;
            link.data_command_select <= 1'b0;
            link.lcd_reset_b         <= 1'b0;
            link.backlight_enable    <= 1'b0;
        end else if (clk_en) begin
            link.lcd_serial_clock  <= next_clk;                   // R14
            link.lcd_chip_select_b <= !next_cs;                   // R16
            link.lcd_serial_in     <= next_cs ? next_bits[7] : 1'b0; // R1 R16

            if (start) begin
                link.data_command_select <= req_is_data;          // R2 R3 R15
            end else if (frame) begin
                link.data_command_select <= dc_hold;              // R15
            end

            link.lcd_reset_b      <= !lcd_reset_req;              // R4
            link.backlight_enable <= backlight_req;               // R5
        end
    end
endmodule : lcd_host_end

// *** lcd_link_props.sv ***
// Purpose: Timing and framing checks on the LCD serial link pins
// Assumes: Host end drives every pin; pins sampled on the 50 MHz clock
// Notes:   Checks stand down while the host end is frozen by clk_en
`timescale 1ns/1ps

module lcd_link_props (
    input  wire logic clk,                 // System clock
    input  wire logic rst_b,               // Synchronous reset, active low
    input  wire logic clk_en,              // Host end run enable
    input  wire logic lcd_serial_clock,    // Serial clock
    input  wire logic lcd_chip_select_b,   // Chip select, active low
    input  wire logic lcd_serial_in,       // Serial data
    input  wire logic data_command_select  // Data or command
);
    // ****************************************
    // Link checks
    // ****************************************
    // A frozen host stretches every count, so a freeze aborts open attempts
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b || !clk_en);

    property p_idle_clock; lcd_chip_select_b |-> !lcd_serial_clock; endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("serial clock moved outside a frame");
    property p_idle_data; lcd_chip_select_b |-> !lcd_serial_in; endproperty
    a_idle_data: assert property (p_idle_data) else $error("data line not low outside a frame");
    property p_select_stable;
        !lcd_chip_select_b && !$past(lcd_chip_select_b) |-> $stable(data_command_select);
    endproperty
    a_select_stable: assert property (p_select_stable) else $error("select changed inside a frame");
    property p_setup; $fell(lcd_chip_select_b) |-> (!lcd_serial_clock) [*8] ##1 lcd_serial_clock; endproperty
    a_setup: assert property (p_setup) else $error("first clock rise not 8 cycles after select");
    property p_clock_high; $rose(lcd_serial_clock) |-> lcd_serial_clock [*8] ##1 !lcd_serial_clock; endproperty
    a_clock_high: assert property (p_clock_high) else $error("serial clock high phase not 8 cycles");
    property p_clock_low;
        $fell(lcd_serial_clock) && !lcd_chip_select_b |-> (!lcd_serial_clock) [*8] ##1 lcd_serial_clock;
    endproperty
    a_clock_low: assert property (p_clock_low) else $error("serial clock low phase not 8 cycles");
    property p_frame; $fell(lcd_chip_select_b) |-> ##127 !lcd_chip_select_b ##1 lcd_chip_select_b; endproperty
    a_frame: assert property (p_frame) else $error("frame length not 128 cycles");
    property p_gap; $rose(lcd_chip_select_b) |-> lcd_chip_select_b [*8]; endproperty
    a_gap: assert property (p_gap) else $error("gap between frames too short");
    // Data may only move while the serial clock is low
    property p_bit_hold; lcd_serial_clock && $past(lcd_serial_clock) |-> $stable(lcd_serial_in); endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("data moved while serial clock high");
endmodule : lcd_link_props

// *** testbench.sv ***
// Purpose: Self-checking bench joining both link ends
// Assumes: Host end makes the serial clock; bench drives on falling edges
// Notes:   Both ends share one enable and freeze together
`timescale 1ns/1ps

module testbench;
    import lcd_link_pkg::*;

    // ****************************************
    // Stimulus table and signals
    // ****************************************
    typedef struct packed { logic d; byte_t b; logic [2:0] sel; byte_t exp; } row_t;
    // Field codes: 0 scan, 1 power, 2 start, 3 page, 4 column, 5 display, 6 written column
    localparam row_t ROWS [16] = '{
        '{1'b0, 8'hc0, 3'h0, 8'h00}, '{1'b0, 8'hcf, 3'h0, 8'h0f}, '{1'b0, 8'h28, 3'h1, 8'h00},
        '{1'b0, 8'h2f, 3'h1, 8'h07}, '{1'b0, 8'h40, 3'h2, 8'h00}, '{1'b0, 8'h7f, 3'h2, 8'h3f},
        '{1'b0, 8'hb8, 3'h3, 8'h08}, '{1'b0, 8'hb3, 3'h3, 8'h03}, '{1'b0, 8'h18, 3'h4, 8'h18},
        '{1'b0, 8'h05, 3'h4, 8'h05}, '{1'b0, 8'haf, 3'h5, 8'h01}, '{1'b0, 8'hae, 3'h5, 8'h00},
        '{1'b0, 8'hd0, 3'h0, 8'h0f}, '{1'b1, 8'ha5, 3'h6, 8'h05}, '{1'b1, 8'h3c, 3'h4, 8'h07},
        '{1'b0, 8'hb0, 3'h3, 8'h00}};
    logic       clk = 1'b0, rst_b = 1'b0, host_clk_en = 1'b1, req_valid = 1'b0, req_is_data = 1'b0;
    logic       backlight_req = 1'b0, lcd_reset_req = 1'b0, sclk_q = 1'b0, wire_dc = 1'b0;
    byte_t      req_byte = 8'h00, wire_byte = 8'h00, pix_byte, cmd_byte;
    logic       req_ready, req_refused, host_init_done, busy, lcd_in_reset, backlight_on, display_on;
    logic       lcd_init_done, pix_valid, cmd_valid, early_data;
    logic [5:0] start_line;
    logic [3:0] page, scan_mode, pix_page;
    logic [7:0] column, pix_column;
    logic [2:0] power_mode, snap;
    int         bad_count = 0, tests_run = 0, cmd_cnt = 0, pix_cnt = 0, ref_cnt = 0, c0, p0, r0;

    lcd_link_if link ();
    lcd_host_end lcd_host_end_inst (.clk(clk), .rst_b(rst_b), .clk_en(host_clk_en), .req_valid(req_valid),
        .req_ready(req_ready), .req_is_data(req_is_data), .req_byte(req_byte), .req_refused(req_refused),
        .backlight_req(backlight_req), .lcd_reset_req(lcd_reset_req), .init_done(host_init_done),
        .busy(busy), .link(link.host));
    lcd_lcd_end lcd_lcd_end_inst (.clk(clk), .rst_b(rst_b), .clk_en(host_clk_en), .link(link.lcd),
        .lcd_in_reset(lcd_in_reset), .backlight_on(backlight_on), .display_on(display_on),
        .start_line(start_line), .page(page), .column(column), .scan_mode(scan_mode),
        .power_mode(power_mode), .init_done(lcd_init_done), .pix_valid(pix_valid), .pix_page(pix_page),
        .pix_column(pix_column), .pix_byte(pix_byte), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .early_data(early_data));
    lcd_link_props lcd_link_props_inst (.clk(clk), .rst_b(rst_b), .clk_en(host_clk_en),
        .lcd_serial_clock(link.lcd_serial_clock), .lcd_chip_select_b(link.lcd_chip_select_b),
        .lcd_serial_in(link.lcd_serial_in), .data_command_select(link.data_command_select));

    always #10 clk = ~clk;

    // Wire sniffer and strobe counters; bits are taken on each serial clock rise
    always @(posedge clk) begin
        sclk_q <= link.lcd_serial_clock;
        if (link.lcd_serial_clock && !sclk_q && !link.lcd_chip_select_b) begin
            wire_byte <= {wire_byte[6:0], link.lcd_serial_in};
            wire_dc <= link.data_command_select;
        end
        if (cmd_valid === 1'b1) cmd_cnt <= cmd_cnt + 1;
        if (pix_valid === 1'b1) pix_cnt <= pix_cnt + 1;
        if (req_refused === 1'b1) ref_cnt <= ref_cnt + 1;
    end

    // ****************************************
    // Tasks
    // ****************************************
    function automatic byte_t field(input logic [2:0] s);
        case (s)
            3'h0: field = {4'h0, scan_mode};
            3'h1: field = {5'h00, power_mode};
            3'h2: field = {2'h0, start_line};
            3'h3: field = {4'h0, page};
            3'h4: field = column;
            3'h5: field = {7'h00, display_on};
            default: field = pix_column;
        endcase
    endfunction : field

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask : check

    // Holds the offer until taken, then waits out the frame under a bound
    task automatic send(input logic d, input byte_t b);
        int n;
        n = 0;
        @(negedge clk);
        req_valid = 1'b1;
        req_is_data = d;
        req_byte = b;
        while (req_ready !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        while (busy === 1'b1 && n < 600) begin
            @(negedge clk);
            n++;
        end
        check(16'(n >= 300), 16'h0000);
        repeat (6) @(negedge clk);
    endtask : send

    task automatic finish_test();
        $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (3) @(negedge clk);
        check({12'h0, link.lcd_chip_select_b, link.lcd_serial_clock, link.lcd_reset_b, link.backlight_enable},
              16'h0008);
        repeat (1) @(negedge clk);
        rst_b = 1'b1;
        repeat (6) @(negedge clk);
        check({12'h0, link.lcd_reset_b, lcd_in_reset, lcd_init_done, host_init_done}, 16'h0008);
        r0 = ref_cnt;
        send(1'b1, 8'h55);
        check(16'(((ref_cnt - r0) << 8) + pix_cnt), 16'h0100);
        foreach (ROWS[i]) begin
            c0 = cmd_cnt;
            p0 = pix_cnt;
            send(ROWS[i].d, ROWS[i].b);
            check({8'h0, wire_byte}, {8'h0, ROWS[i].b});
            check({7'h0, wire_dc, ROWS[i].d ? pix_byte : cmd_byte}, {7'h0, ROWS[i].d, ROWS[i].b});
            check(16'(((cmd_cnt - c0) << 8) + pix_cnt - p0), ROWS[i].d ? 16'h0001 : 16'h0100);
            check({8'h0, field(ROWS[i].sel)}, {8'h0, ROWS[i].exp});
        end
        check({10'h0, pix_page, host_init_done, lcd_init_done}, 16'h000f);
        // Freeze the host mid-frame: pins must hold, byte must still land
        fork
            send(1'b0, 8'h41);
            begin
                repeat (40) @(negedge clk);
                host_clk_en = 1'b0;
                snap = {link.lcd_serial_clock, link.lcd_chip_select_b, link.lcd_serial_in};
                repeat (30) @(negedge clk);
                check({13'h0, link.lcd_serial_clock, link.lcd_chip_select_b, link.lcd_serial_in},
                      {13'h0, snap});
                host_clk_en = 1'b1;
            end
        join
        check({10'h0, start_line}, 16'h0001);
        backlight_req = 1'b1;
        repeat (6) @(negedge clk);
        check({14'h0, link.backlight_enable, backlight_on}, 16'h0003);
        backlight_req = 1'b0;
        repeat (6) @(negedge clk);
        check({14'h0, link.backlight_enable, backlight_on}, 16'h0000);
        lcd_reset_req = 1'b1;
        repeat (6) @(negedge clk);
        check({link.lcd_reset_b, lcd_in_reset, host_init_done, lcd_init_done, 6'h0, start_line}, 16'h4000);
        lcd_reset_req = 1'b0;
        repeat (6) @(negedge clk);
        r0 = ref_cnt;
        send(1'b1, 8'h99);
        check(16'(ref_cnt - r0), 16'h0001);
        finish_test();
    end

    // Watchdog far beyond the 51 us the run needs
    initial begin
        #400000;
        bad_count++;
        finish_test();
    end
endmodule : testbench
